// *** core/mzc_cmd.sv ***
// multi-turn raw position and zero-offset command handler, can and rs485
// Functional notes
// - request 0x61 with bytes 1 to 7 zero returns the raw position.
// - 0x61 reply: 0x61, three zero bytes, raw position in bytes 4-7.
// - 32-bit values in bytes 4 to 7 are little-endian, byte 4 lowest.
// - request 0x62 with bytes 1 to 7 zero asks for the zero offset.
// - 0x62 reply: 0x62, three zero bytes, stored offset in bytes 4-7.
// - request 0x63 stores the offset in bytes 4-7 non-volatile.
// - an accepted 0x63 request is echoed byte for byte.
// - a new offset is used for position only after a restart.
// - can requests come on identifier 0x141 and replies go on 0x241.
// - rs485 frame is 0x3E, 0x01, 0x08, 8 data bytes, crc low, crc high.
`timescale 1ns/10ps
module mzc_cmd (
  input wire logic i_clk,                // system clock
  input wire logic i_nrst,               // async reset, active low
  input wire logic [31:0] i_raw_position, // raw multi-turn position
  input wire logic [31:0] i_nv_offset,   // offset read from nv memory
  input wire logic i_can_valid,          // can frame received, pulse
  input wire logic [10:0] i_can_id,      // can identifier
  input wire logic [63:0] i_can_data,    // can payload, byte i at 8i
  output logic o_can_valid,              // can reply ready, pulse
  output logic [10:0] o_can_id,          // can reply identifier
  output logic [63:0] o_can_data,        // can reply payload
  input wire logic i_rx_valid,           // rs485 byte received, pulse
  input wire logic [7:0] i_rx_byte,      // rs485 received byte
  output logic o_tx_valid,               // rs485 byte to send
  output logic [7:0] o_tx_byte,          // rs485 byte value
  input wire logic i_tx_ready,           // rs485 sender takes byte
  output logic o_nv_write,               // write nv offset, pulse
  output logic [31:0] o_nv_wdata,        // offset to write
  output logic o_active_offset_vld,      // set from the first clock after reset, a cycle before o_active_offset holds the captured offset
  output logic [31:0] o_active_offset,   // offset in use
  output logic o_rs_crc_error            // bad rs485 checksum, pulse
);

  typedef enum logic [2:0] {
    RX_HEADER = 3'b000,
    RX_ID     = 3'b001,
    RX_LEN    = 3'b010,
    RX_DATA   = 3'b011,
    RX_CRC_LO = 3'b100,
    RX_CRC_HI = 3'b101
  } mzc_rx_e;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } mzc_tx_e;

  mzc_rx_e rx_state;
  mzc_tx_e tx_state;
  logic [2:0] rx_cnt;
  logic [63:0] rx_payload;
  logic [15:0] rx_crc;
  logic [7:0] checksum_low_byte;
  logic rx_done;
  logic rx_good;
  logic [3:0] tx_idx;
  logic [63:0] tx_payload;
  logic [15:0] tx_crc;
  logic [15:0] next_tx_crc;
  logic can_req;
  logic can_wr;
  logic rs_go;
  mzc_pkg::mzc_reply_s can_rep;
  mzc_pkg::mzc_reply_s rs_rep;

  mzc_ofs_if ofs ();

  mzc_ofs_store u_store (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_nv_offset(i_nv_offset),
    .ofs(ofs)
  );

  assign ofs.wr = o_nv_write;
  assign ofs.wdata = o_nv_wdata;

  // byte of an outgoing rs485 frame at a given index
  function automatic logic [7:0] tx_byte_at(input logic [3:0] idx,
                                            input logic [63:0] pl,
                                            input logic [15:0] crc);
    logic [3:0] d;
    logic [7:0] b;
    d = idx - mzc_pkg::RS_IDX_DATA0;
    b = pl[{d[2:0], 3'b000} +: 8];
    if (idx == mzc_pkg::RS_IDX_HEADER)
      b = mzc_pkg::RS_HEADER;
    else if (idx == mzc_pkg::RS_IDX_ID)
      b = mzc_pkg::RS_MOTOR_ID;
    else if (idx == mzc_pkg::RS_IDX_LEN)
      b = mzc_pkg::RS_LENGTH;
    else if (idx == mzc_pkg::RS_IDX_CRC_LO)
      b = crc[7:0];
    else if (idx == mzc_pkg::RS_IDX_CRC_HI)
      b = crc[15:8];
    return b;
  endfunction

  // ------------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------------
  assign can_req = i_can_valid
                   && i_can_id == mzc_pkg::CAN_REQ_ID;
  assign can_rep = mzc_pkg::mzc_decode(i_can_data, i_raw_position,
                                       ofs.stored);
  assign rs_rep = mzc_pkg::mzc_decode(rx_payload, i_raw_position,
                                      ofs.stored);
  assign can_wr = can_req && can_rep.wr;
  // a write from can in the same cycle takes the nv port; rs reply is dropped
  assign rs_go = rx_done && rx_good && rs_rep.ok && tx_state == TX_IDLE
                 && !can_wr;

  // ------------------------------------------------------------------
  // can reply
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_can_valid <= 1'b0;
      o_can_id <= mzc_pkg::CAN_RSP_ID;
      o_can_data <= mzc_pkg::PAYLOAD_RESET;
    end
    else
    begin
      o_can_valid <= can_req && can_rep.ok;
      o_can_id <= mzc_pkg::CAN_RSP_ID;
      if (can_req && can_rep.ok)
        o_can_data <= can_rep.payload;
    end
  end

  // ------------------------------------------------------------------
  // nv write and status
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_nv_write <= 1'b0;
      o_nv_wdata <= mzc_pkg::OFS_RESET;
    end
    else
    begin
      o_nv_write <= can_wr || (rs_go && rs_rep.wr);
      if (can_wr)
        o_nv_wdata <= i_can_data[63:32];
      else if (rs_go && rs_rep.wr)
        o_nv_wdata <= rx_payload[63:32];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_active_offset <= mzc_pkg::OFS_RESET;
      o_active_offset_vld <= 1'b0;
      o_rs_crc_error <= 1'b0;
    end
    else
    begin
      o_active_offset <= ofs.active;
      o_active_offset_vld <= 1'b1;
      o_rs_crc_error <= rx_done && !rx_good;
    end
  end

  // ------------------------------------------------------------------
  // rs485 receiver
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rx_state <= RX_HEADER;
      rx_cnt <= 3'h0;
      rx_payload <= mzc_pkg::PAYLOAD_RESET;
      rx_crc <= mzc_pkg::CRC_INIT;
      checksum_low_byte <= 8'h00;
      rx_done <= 1'b0;
      rx_good <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (i_rx_valid)
      begin
        unique case (rx_state)
          RX_HEADER:
          begin
            if (i_rx_byte == mzc_pkg::RS_HEADER)
            begin
              rx_crc <= mzc_pkg::mzc_crc_byte(mzc_pkg::CRC_INIT, i_rx_byte);
              rx_state <= RX_ID;
            end
          end
          RX_ID:
          begin
            rx_crc <= mzc_pkg::mzc_crc_byte(rx_crc, i_rx_byte);
            rx_state <= (i_rx_byte == mzc_pkg::RS_MOTOR_ID) ? RX_LEN
                                                           : RX_HEADER;
          end
          RX_LEN:
          begin
            rx_crc <= mzc_pkg::mzc_crc_byte(rx_crc, i_rx_byte);
            rx_cnt <= 3'h0;
            rx_state <= (i_rx_byte == mzc_pkg::RS_LENGTH) ? RX_DATA
                                                         : RX_HEADER;
          end
          RX_DATA:
          begin
            rx_crc <= mzc_pkg::mzc_crc_byte(rx_crc, i_rx_byte);
            rx_payload[{rx_cnt, 3'b000} +: 8] <= i_rx_byte;
            rx_cnt <= rx_cnt + 3'h1;
            if (rx_cnt == mzc_pkg::RS_LAST_DATA)
              rx_state <= RX_CRC_LO;
          end
          RX_CRC_LO:
          begin
            checksum_low_byte <= i_rx_byte;
            rx_state <= RX_CRC_HI;
          end
          RX_CRC_HI:
          begin
            rx_done <= 1'b1;
            rx_good <= {i_rx_byte, checksum_low_byte} == rx_crc;
            rx_state <= RX_HEADER;
          end
          default:
            rx_state <= RX_HEADER;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // rs485 sender
  // ------------------------------------------------------------------
  assign next_tx_crc = (tx_idx < mzc_pkg::RS_IDX_CRC_LO)
                       ? mzc_pkg::mzc_crc_byte(tx_crc, o_tx_byte) : tx_crc;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tx_state <= TX_IDLE;
      tx_idx <= mzc_pkg::RS_IDX_HEADER;
      tx_payload <= mzc_pkg::PAYLOAD_RESET;
      tx_crc <= mzc_pkg::CRC_INIT;
      o_tx_valid <= 1'b0;
      o_tx_byte <= 8'h00;
    end
    else
    begin
      unique case (tx_state)
        TX_IDLE:
        begin
          if (rs_go)
          begin
            tx_payload <= rs_rep.payload;
            tx_idx <= mzc_pkg::RS_IDX_HEADER;
            tx_crc <= mzc_pkg::CRC_INIT;
            o_tx_valid <= 1'b1;
            o_tx_byte <= mzc_pkg::RS_HEADER;
            tx_state <= TX_SEND;
          end
        end
        TX_SEND:
        begin
          if (i_tx_ready)
          begin
            tx_crc <= next_tx_crc;
            if (tx_idx == mzc_pkg::RS_IDX_CRC_HI)
            begin
              o_tx_valid <= 1'b0;
              tx_state <= TX_IDLE;
            end
            else
            begin
              tx_idx <= tx_idx + 4'h1;
              o_tx_byte <= tx_byte_at(tx_idx + 4'h1, tx_payload,
                                      next_tx_crc);
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cmd_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  a_can_reply_id: assert property (
    o_can_valid |-> o_can_id == 11'h241) else $error("bad can reply id");
  a_raw_reply: assert property (
    can_req && i_can_data == {32'h0, 24'h0, 8'h61}
    |=> o_can_valid && o_can_data[7:0] == 8'h61) else $error("no raw reply");
  a_raw_payload: assert property (
    can_req && i_can_data == {32'h0, 24'h0, 8'h61}
    |=> o_can_data == {$past(i_raw_position), 24'h0, 8'h61})
    else $error("raw read payload wrong");
  a_ofs_payload: assert property (
    can_req && i_can_data == {32'h0, 24'h0, 8'h62}
    |=> o_can_valid && o_can_data == {$past(ofs.stored), 24'h0, 8'h62})
    else $error("offset read payload wrong");
  a_echo_write: assert property (
    can_req && i_can_data[31:0] == {24'h0, 8'h63}
    |=> o_can_valid && o_can_data == $past(i_can_data)) else $error("no echo");
  a_nv_write: assert property (
    can_req && i_can_data[31:0] == {24'h0, 8'h63}
    |=> o_nv_write && o_nv_wdata == $past(i_can_data[63:32]))
    else $error("offset write not stored");
  a_bad_crc_quiet: assert property (
    rx_done && !rx_good && tx_state == TX_IDLE
    |=> tx_state == TX_IDLE ##1 !o_tx_valid) else $error("reply to bad crc");
  a_tx_frame_head: assert property (
    $rose(o_tx_valid) |-> o_tx_byte == 8'h3E
    ##1 (o_tx_byte == 8'h3E || o_tx_byte == 8'h01))
    else $error("rs485 frame header wrong");
  a_active_stable: assert property (
    o_nv_write |=> ##1 $stable(o_active_offset)) else $error("offset moved");
  c_rs_reply: cover property (rs_go ##1 o_tx_valid);
  c_can_write: cover property (can_wr ##1 o_nv_write);
  c_crc_error: cover property (o_rs_crc_error);

endmodule // mzc_cmd

// *** core/mzc_ofs_if.sv ***
// link between the command logic and the zero-offset store
`timescale 1ns/10ps
interface mzc_ofs_if;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] stored;
  logic [31:0] active;

  modport cmd (output wr, output wdata, input stored, input active);
  modport store (input wr, input wdata, output stored, output active);
endinterface

// *** core/mzc_ofs_store.sv ***
// zero-offset store: non-volatile copy and the offset in use
`timescale 1ns/10ps
module mzc_ofs_store (
  input wire logic i_clk,           // system clock
  input wire logic i_nrst,          // async reset, active low
  input wire logic [31:0] i_nv_offset, // offset held in non-volatile memory
  mzc_ofs_if.store ofs              // command side
);

  logic loaded;

  // ------------------------------------------------------------------
  // capture after reset release; the stored copy then follows writes
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      loaded <= 1'b0;
    else
      loaded <= 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ofs.stored <= mzc_pkg::OFS_RESET;
    else if (!loaded)
      ofs.stored <= i_nv_offset;
    else if (ofs.wr)
      ofs.stored <= ofs.wdata;
  end

  // offset in use only changes at restart
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ofs.active <= mzc_pkg::OFS_RESET;
    else if (!loaded)
      ofs.active <= i_nv_offset;
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking st_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  a_active_hold: assert property (
    loaded |=> $stable(ofs.active))
    else $error("active offset changed without restart");

  a_store_write: assert property (
    loaded && ofs.wr |=> ofs.stored == $past(ofs.wdata))
    else $error("stored offset did not take written value");

  c_write_seen: cover property (@(posedge i_clk) disable iff (!i_nrst)
    loaded && ofs.wr ##1 ofs.stored != ofs.active);

endmodule // mzc_ofs_store

// *** core/mzc_pkg.sv ***
// constants, types and helpers shared by the zero-offset command block
package mzc_pkg;

  // ------------------------------------------------------------------
  // command bytes
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_RAW_READ = 8'h61;
  localparam logic [7:0] CMD_OFS_READ = 8'h62;
  localparam logic [7:0] CMD_OFS_WRITE = 8'h63;

  // ------------------------------------------------------------------
  // can identifiers
  // ------------------------------------------------------------------
  localparam logic [10:0] CAN_REQ_ID = 11'h141;
  localparam logic [10:0] CAN_RSP_ID = 11'h241;

  // ------------------------------------------------------------------
  // rs485 framing
  // ------------------------------------------------------------------
  localparam logic [7:0] RS_HEADER = 8'h3E;
  localparam logic [7:0] RS_MOTOR_ID = 8'h01;
  localparam logic [7:0] RS_LENGTH = 8'h08;
  localparam logic [3:0] RS_IDX_HEADER = 4'h0;
  localparam logic [3:0] RS_IDX_ID = 4'h1;
  localparam logic [3:0] RS_IDX_LEN = 4'h2;
  localparam logic [3:0] RS_IDX_DATA0 = 4'h3;
  localparam logic [3:0] RS_IDX_CRC_LO = 4'hB;
  localparam logic [3:0] RS_IDX_CRC_HI = 4'hC;
  localparam logic [2:0] RS_LAST_DATA = 3'h7;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] OFS_RESET = 32'h0000_0000;
  localparam logic [63:0] PAYLOAD_RESET = 64'h0;

  typedef struct packed {
    logic ok;
    logic wr;
    logic [63:0] payload;
  } mzc_reply_s;

  // reflected crc16, one byte
  function automatic logic [15:0] mzc_crc_byte(input logic [15:0] crc,
                                               input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      if (c[0])
        c = (c >> 1) ^ CRC_POLY;
      else
        c = c >> 1;
    end
    return c;
  endfunction

  // builds the reply to one 8-byte request; ok low means no reply
  function automatic mzc_reply_s mzc_decode(input logic [63:0] req,
                                            input logic [31:0] raw,
                                            input logic [31:0] ofs);
    mzc_reply_s r;
    r = '0;
    if (req[31:8] == 24'h0)
    begin
      if (req[7:0] == CMD_RAW_READ && req[63:32] == 32'h0)
      begin
        r.ok = 1'b1;
        r.payload = {raw, 24'h0, CMD_RAW_READ};
      end
      else if (req[7:0] == CMD_OFS_READ && req[63:32] == 32'h0)
      begin
        r.ok = 1'b1;
        r.payload = {ofs, 24'h0, CMD_OFS_READ};
      end
      else if (req[7:0] == CMD_OFS_WRITE)
      begin
        r.ok = 1'b1;
        r.wr = 1'b1;
        r.payload = req;
      end
    end
    return r;
  endfunction

endpackage

// *** verification/mzc_cmd_tb_top.sv ***
// self-checking bench for the zero-offset command handler
`timescale 1ns/10ps
module mzc_cmd_tb_top;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [31:0] raw = 32'h0;
  logic [31:0] nvo = 32'h1234_5678;
  logic cv = 1'h0;
  logic [10:0] cid = 11'h0;
  logic [63:0] cdat = 64'h0;
  logic rv = 1'h0;
  logic [7:0] rb = 8'h0;
  logic clr = 1'h0;
  logic ocv, otv, rdy, nvw, aov, crce;
  logic [10:0] ocid;
  logic [63:0] ocdat;
  logic [7:0] otb;
  logic [31:0] nvwd, ao;
  logic [4:0] cnt;
  int mismatches = 0;
  int checks = 0;

  always #4 clk = ~clk;

  mzc_cmd dut (.i_clk(clk), .i_nrst(nrst), .i_raw_position(raw),
    .i_nv_offset(nvo), .i_can_valid(cv), .i_can_id(cid),
    .i_can_data(cdat), .o_can_valid(ocv), .o_can_id(ocid),
    .o_can_data(ocdat), .i_rx_valid(rv), .i_rx_byte(rb),
    .o_tx_valid(otv), .o_tx_byte(otb), .i_tx_ready(rdy),
    .o_nv_write(nvw), .o_nv_wdata(nvwd), .o_active_offset_vld(aov),
    .o_active_offset(ao), .o_rs_crc_error(crce));

  mzc_host_model host (.i_clk(clk), .i_nrst(nrst), .i_clear(clr),
    .i_tx_valid(otv), .i_tx_byte(otb), .o_tx_ready(rdy),
    .o_count(cnt));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic restart();
    @(posedge clk);
    nrst <= 1'h0;
    repeat (20) @(posedge clk);
    #1 chk(ocid, 64'h241);
    chk(ocv, 64'h0);
    @(posedge clk);
    nrst <= 1'h1;
    repeat (2) @(posedge clk);
    #1 chk(aov, 64'h1);
    chk(ao, nvo);
  endtask

  task automatic can_req(input logic [10:0] id, input logic [63:0] d,
                         input logic ok, input logic [63:0] e);
    @(posedge clk);
    cv <= 1'h1;
    cid <= id;
    cdat <= d;
    @(posedge clk);
    cv <= 1'h0;
    #1 chk(ocv, ok);
    chk(nvw, ok && d[7:0] == 8'h63);
    if (ok)
    begin
      chk(ocdat, e);
      chk(ocid, 64'h241);
      if (d[7:0] == 8'h63)
        chk(nvwd, d[63:32]);
    end
    @(posedge clk);
    #1 chk(ocv, 64'h0);
  endtask

  task automatic build(input logic [63:0] pl, output logic [7:0] f [0:12]);
    logic [15:0] c;
    f[0] = 8'h3E;
    f[1] = 8'h01;
    f[2] = 8'h08;
    for (int i = 0; i < 8; i++)
      f[3 + i] = pl[8 * i +: 8];
    c = 16'hFFFF;
    for (int i = 0; i < 11; i++)
    begin
      c = c ^ {8'h00, f[i]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    f[11] = c[7:0];
    f[12] = c[15:8];
  endtask

  task automatic rs_send(input logic [63:0] pl, input logic bad);
    logic [7:0] f [0:12];
    build(pl, f);
    if (bad)
      f[11] = ~f[11];
    for (int i = 0; i < 13; i++)
    begin
      @(posedge clk);
      rv <= 1'h1;
      rb <= f[i];
    end
    @(posedge clk);
    rv <= 1'h0;
  endtask

  task automatic rs_expect(input logic [63:0] pl);
    logic [7:0] f [0:12];
    int n;
    build(pl, f);
    n = 0;
    while (cnt !== 5'hD && n < 200)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(cnt, 64'hD);
    for (int i = 0; i < 13; i++)
      chk(host.got[i], f[i]);
    @(posedge clk);
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_raw_read();
    logic [31:0] v [0:1];
    v[0] = 32'h8765_4321;
    v[1] = 32'hFFFF_FFFE;
    for (int i = 0; i < 2; i++)
    begin
      raw <= v[i];
      can_req(11'h141, 64'h61, 1'h1,
              {v[i], 32'h61});
    end
  endtask

  task automatic t_refuse();
    can_req(11'h142, 64'h61, 1'h0, 64'h0);
    can_req(11'h141, 64'h100_0061, 1'h0, 64'h0);
    can_req(11'h141, 64'h1_0000_0062, 1'h0, 64'h0);
    can_req(11'h141, 64'h64, 1'h0, 64'h0);
  endtask

  task automatic t_write();
    can_req(11'h141, 64'h62, 1'h1, {nvo, 32'h62});
    can_req(11'h141, 64'h2710_0000_0063, 1'h1,
            64'h2710_0000_0063);
    can_req(11'h141, 64'h62, 1'h1, 64'h2710_0000_0062);
    chk(ao, nvo);
  endtask

  task automatic t_rs();
    raw <= 32'hA5C3_0F81;
    rs_send(64'h61, 1'h0);
    rs_expect(64'hA5C3_0F81_0000_0061);
    rs_send(64'hFEDC_BA98_0000_0063, 1'h0);
    rs_expect(64'hFEDC_BA98_0000_0063);
    can_req(11'h141, 64'h62, 1'h1, 64'hFEDC_BA98_0000_0062);
    chk(ao, nvo);
  endtask

  task automatic t_bad_crc();
    int n;
    rs_send(64'h62, 1'h1);
    n = 0;
    while (crce !== 1'h1 && n < 10)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(crce, 64'h1);
    repeat (40) @(posedge clk);
    #1 chk(cnt, 64'h0);
  endtask

  task automatic t_restart();
    nvo <= 32'hFEDC_BA98;
    restart();
    chk(ao, 64'hFEDC_BA98);
    // host re-reads the zero offset before placing new targets
    can_req(11'h141, 64'h62, 1'h1, 64'hFEDC_BA98_0000_0062);
  endtask

  initial
  begin
    #100000;
    mismatches++;
    final_report();
  end

  initial
  begin
    restart();
    t_raw_read();
    t_refuse();
    t_write();
    t_rs();
    t_bad_crc();
    t_restart();
    final_report();
  end
endmodule // mzc_cmd_tb_top

// *** verification/mzc_host_model.sv ***
// host-side model that takes the rs485 reply bytes, stalling as it goes
`timescale 1ns/10ps
module mzc_host_model (
  input wire logic i_clk,           // system clock
  input wire logic i_nrst,          // async reset, active low
  input wire logic i_clear,         // forget bytes taken so far
  input wire logic i_tx_valid,      // reply byte offered
  input wire logic [7:0] i_tx_byte, // reply byte value
  output logic o_tx_ready,          // byte taken on this edge
  output logic [4:0] o_count        // bytes taken since clear
);
  logic [7:0] got [0:15];

  // --------------------------------------------------------------
  // stall every other cycle so the sender has to hold its byte
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      o_tx_ready <= 1'h0;
    else
      o_tx_ready <= ~o_tx_ready;

  // keeps bytes in arrival order, header first
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_count <= 5'h0;
    else if (i_clear)
      o_count <= 5'h0;
    else if (i_tx_valid && o_tx_ready)
    begin
      got[o_count[3:0]] <= i_tx_byte;
      o_count <= o_count + 5'h1;
    end
  end
endmodule // mzc_host_model
